// ===== pvft_map.svh
// timing limits, widths and reset constants of the parallel video frame source
`ifndef PVFT_MAP_SVH
`define PVFT_MAP_SVH

// ----------------------------------------
// widths
// ----------------------------------------
`define PVFT_CW 12
`define PVFT_PIX_W 24
`define PVFT_AGE_W 17
`define PVFT_RST_W 8

// ----------------------------------------
// time figures and clock rate
// ----------------------------------------
`define PVFT_CORE_NS 8.0
`define PVFT_NS_PER_MS 1.0e6
`define PVFT_NS_PER_US 1.0e3
`define PVFT_EYE_MS 1.0
`define PVFT_RST_US 1.25

// ----------------------------------------
// frame and line limits
// ----------------------------------------
`define PVFT_VSW_MIN 12'h001
`define PVFT_VBP_MIN 12'h002
`define PVFT_VFP_MIN 12'h001
`define PVFT_TVB_BASE 12'h006
`define PVFT_TVB_MUL 12'h008
`define PVFT_HSW_MIN 12'h004
`define PVFT_HSW_MAX 12'h080
`define PVFT_HBP_MIN 12'h004
`define PVFT_HFP_MIN 12'h008
`define PVFT_ACT_MIN 12'h001
`define PVFT_ARR_MIN 12'h001
`define PVFT_LINE_ONE 12'h001

`endif

// ===== pvft_pkg.sv
// types and helper functions shared by the parallel video frame source
`include "pvft_map.svh"

package pvft_pkg;

    // ----------------------------------------
    // configuration and pin groups
    // ----------------------------------------
    typedef logic [`PVFT_CW-1:0] pvft_cnt_t;
    typedef logic [`PVFT_AGE_W-1:0] pvft_age_t;

    typedef struct packed {
        pvft_cnt_t sync_w;
        pvft_cnt_t back_porch;
        pvft_cnt_t active;
        pvft_cnt_t front_porch;
    } pvft_hcfg_t;

    typedef struct packed {
        pvft_cnt_t sync_lines;
        pvft_cnt_t back_porch;
        pvft_cnt_t source_active_lines;
        pvft_cnt_t front_porch;
        pvft_cnt_t array_used_lines;
    } pvft_vcfg_t;

    typedef struct packed {
        logic frame_sync;
        logic line_sync;
        logic pixel_valid;
        logic stereo_eye_select;
        logic [`PVFT_PIX_W-1:0] pixel_bus;
    } pvft_pins_t;

    // ----------------------------------------
    // state types
    // ----------------------------------------
    typedef enum logic [1:0] {PVFT_H_SYNC, PVFT_H_BP, PVFT_H_ACT, PVFT_H_FP} pvft_hphase_t;
    typedef enum logic [1:0] {PVFT_V_TOP, PVFT_V_ACT, PVFT_V_BOT} pvft_vphase_t;

    typedef struct packed {
        pvft_hphase_t phase;
        pvft_cnt_t cnt;
    } pvft_hstate_t;

    typedef struct packed {
        logic [`PVFT_RST_W-1:0] cnt;
        logic rst_low;
    } pvft_rstate_t;

    typedef struct packed {
        logic pclk;
        pvft_vphase_t vph;
        pvft_cnt_t line;
        pvft_pins_t pins;
        pvft_age_t vs_age;
        pvft_age_t eye_age;
    } pvft_mstate_t;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic pvft_cnt_t pvft_max(input pvft_cnt_t a, input pvft_cnt_t b);
        return (a > b) ? a : b;
    endfunction : pvft_max

    function automatic pvft_cnt_t pvft_sat_cnt(input pvft_cnt_t a);
        return (&a) ? a : a + 1'b1;
    endfunction : pvft_sat_cnt

    function automatic pvft_age_t pvft_sat_age(input pvft_age_t a);
        return (&a) ? a : a + 1'b1;
    endfunction : pvft_sat_age

endpackage : pvft_pkg

// ===== pvft_reset_pulse.sv
// active-low reset pulse generator for the display controller
`timescale 1ns/100ps
`include "pvft_map.svh"

module pvft_reset_pulse (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // request
    input wire logic i_reset_req,
    // pin
    output logic o_system_reset_low
);
    import pvft_pkg::*;

    localparam logic [`PVFT_RST_W-1:0] RST_CYC =
        `PVFT_RST_W'(int'($ceil(`PVFT_RST_US * `PVFT_NS_PER_US / `PVFT_CORE_NS)));
    localparam pvft_rstate_t R_RST = '{cnt: RST_CYC, rst_low: 1'b0};

    pvft_rstate_t s;
    pvft_rstate_t next_s;

    // ----------------------------------------
    // pulse timer
    // ----------------------------------------
    always_comb begin
        next_s = s;
        if (i_reset_req) begin
            next_s.cnt = RST_CYC;
        end else if (s.cnt != '0) begin
            next_s.cnt = s.cnt - 1'b1;
        end
        next_s.rst_low = (next_s.cnt == '0);
    end

    // system reset also restarts the full pulse
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            s <= R_RST;
        end else begin
            s <= next_s;
        end
    end

    assign o_system_reset_low = s.rst_low;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    logic [`PVFT_RST_W-1:0] low_run;

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            low_run <= '0;
        end else if (o_system_reset_low) begin
            low_run <= '0;
        end else if (low_run != '1) begin
            low_run <= low_run + 1'b1;
        end
    end

    a_reset_low_width: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        $rose(o_system_reset_low) |-> low_run >= RST_CYC)
        else $error("reset pulse shorter than minimum");

    c_reset_pulse: cover property (@(posedge i_core_clk) disable iff (i_sys_rst)
        $rose(o_system_reset_low));

endmodule : pvft_reset_pulse

// ===== pvft_line_timer.sv
// horizontal sync, porch and active-window sequencer in pixel clock periods
`timescale 1ns/100ps
`include "pvft_map.svh"

module pvft_line_timer (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // pixel period strobe and geometry
    input wire logic i_tick,
    input wire pvft_pkg::pvft_hcfg_t i_hcfg,
    // timing view for the next pixel period
    output logic o_line_start,
    output logic o_sync_next,
    output logic o_act_next
);
    import pvft_pkg::*;

    localparam pvft_hstate_t H_RST = '{phase: PVFT_H_FP, cnt: '0};

    pvft_hstate_t s;
    pvft_hstate_t next_s;
    pvft_cnt_t len;
    pvft_hphase_t nxt;
    logic last;

    // ----------------------------------------
    // phase sequencer
    // ----------------------------------------
    always_comb begin
        next_s = s;
        case (s.phase)
            PVFT_H_SYNC: begin
                len = pvft_max(i_hcfg.sync_w, `PVFT_HSW_MIN);
                if (len > `PVFT_HSW_MAX) begin
                    len = `PVFT_HSW_MAX;
                end
                nxt = PVFT_H_BP;
            end
            PVFT_H_BP: begin
                len = pvft_max(i_hcfg.back_porch, `PVFT_HBP_MIN);
                nxt = PVFT_H_ACT;
            end
            PVFT_H_ACT: begin
                len = pvft_max(i_hcfg.active, `PVFT_ACT_MIN);
                nxt = PVFT_H_FP;
            end
            default: begin
                len = pvft_max(i_hcfg.front_porch, `PVFT_HFP_MIN);
                nxt = PVFT_H_SYNC;
            end
        endcase
        // a shrunk setting mid-phase ends the phase at once
        last = (s.cnt >= len - 1'b1);
        if (i_tick) begin
            if (last) begin
                next_s.phase = nxt;
                next_s.cnt = '0;
            end else begin
                next_s.cnt = s.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            s <= H_RST;
        end else begin
            s <= next_s;
        end
    end

    assign o_line_start = i_tick && last && (s.phase == PVFT_H_FP);
    assign o_sync_next = (next_s.phase == PVFT_H_SYNC);
    assign o_act_next = (next_s.phase == PVFT_H_ACT);

endmodule : pvft_line_timer

// ===== pvft_source.sv
// parallel video source driving frame sync, line sync, valid strobe, pixels and eye select
`timescale 1ns/100ps
`include "pvft_map.svh"

// Overview of operation
// - frame sync is held high for at least one full line time.
// - at least two lines pass from the frame sync rise to the line sync of the first active line.
// - at least one line passes from the line sync after the last active line to frame sync.
// - total vertical blanking is at least 6 plus 8 times max(1, source lines / array lines).
// - line sync is high for between 4 and 128 pixel clocks.
// - at least 4 pixel clocks pass from the line sync rise to the valid strobe rise.
// - at least 8 pixel clocks pass from the valid strobe fall to the next line sync rise.
// - eye select changes at least 1.0 ms before frame sync changes.
// - eye select stays put for at least 1.0 ms after each frame sync change.
// - the active-low system reset is held low for at least 1.25 us.
// - the pixel clock runs between 1.0 and 155.0 MHz with bounded jitter.
module pvft_source #(
    parameter int EYE_HOLD_CYC =
        int'($ceil(`PVFT_EYE_MS * `PVFT_NS_PER_MS / `PVFT_CORE_NS))
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // control
    input wire logic i_video_en,
    input wire logic i_reset_req,
    input wire logic i_eye_req,
    input wire pvft_pkg::pvft_hcfg_t i_hcfg,
    input wire pvft_pkg::pvft_vcfg_t i_vcfg,
    // pixel feed
    input wire logic [`PVFT_PIX_W-1:0] i_pixel,
    output logic o_pixel_take,
    output logic o_frame_start,
    // link pins
    output logic o_pixel_clk,
    output pvft_pkg::pvft_pins_t o_pins,
    output logic o_system_reset_low
);
    import pvft_pkg::*;

    localparam int PW = 2 * `PVFT_CW + 1;
    localparam pvft_age_t EYE_LIM = `PVFT_AGE_W'(EYE_HOLD_CYC);
    localparam pvft_mstate_t M_RST = '{
        pclk: 1'b0, vph: PVFT_V_BOT, line: '0, pins: '0, vs_age: '0, eye_age: '0
    };

    pvft_mstate_t s;
    pvft_mstate_t next_s;
    logic tick;
    logic ls;
    logic sync_next;
    logic act_next;
    logic rst_low;
    logic start;
    logic eye_ok;
    logic tvb_ok;
    logic take;
    pvft_cnt_t vsw;
    pvft_cnt_t vtop;
    pvft_cnt_t vact;
    pvft_cnt_t vfp;
    pvft_cnt_t arr;
    logic [`PVFT_CW:0] blank;
    logic [PW-1:0] floor_need;

    // ----------------------------------------
    // sub-blocks
    // ----------------------------------------
    pvft_line_timer u_line (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_tick(tick),
        .i_hcfg(i_hcfg),
        .o_line_start(ls),
        .o_sync_next(sync_next),
        .o_act_next(act_next)
    );

    pvft_reset_pulse u_rst (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_reset_req(i_reset_req),
        .o_system_reset_low(rst_low)
    );

    // ----------------------------------------
    // frame geometry
    // ----------------------------------------
    always_comb begin
        vsw = pvft_max(i_vcfg.sync_lines, `PVFT_VSW_MIN);
        vtop = pvft_max(pvft_max(i_vcfg.back_porch, `PVFT_VBP_MIN), vsw);
        vact = pvft_max(i_vcfg.source_active_lines, `PVFT_ACT_MIN);
        vfp = pvft_max(i_vcfg.front_porch, `PVFT_VFP_MIN);
        arr = pvft_max(i_vcfg.array_used_lines, `PVFT_ARR_MIN);
        blank = {1'b0, vtop} + {1'b0, s.line};
        // cross-multiplied so no divider is needed for the line ratio
        floor_need = PW'(pvft_max(vact, arr)) * PW'(`PVFT_TVB_MUL);
        tvb_ok = (blank > {1'b0, `PVFT_TVB_BASE})
            && (PW'(blank - {1'b0, `PVFT_TVB_BASE}) * PW'(arr) >= floor_need);
    end

    // ----------------------------------------
    // frame sequencer and pin drive
    // ----------------------------------------
    // core clock halved: 62.5 MHz pixel clock, no jitter beyond the core's
    assign tick = s.pclk;

    always_comb begin
        next_s = s;
        next_s.pclk = ~s.pclk;
        eye_ok = (s.eye_age >= EYE_LIM);
        start = ls && (s.vph == PVFT_V_BOT) && i_video_en && rst_low
            && (s.line >= vfp) && tvb_ok && eye_ok;
        if (ls) begin
            case (s.vph)
                PVFT_V_TOP: begin
                    if (s.line >= vtop) begin
                        next_s.vph = PVFT_V_ACT;
                        next_s.line = `PVFT_LINE_ONE;
                    end else begin
                        next_s.line = pvft_sat_cnt(s.line);
                    end
                end
                PVFT_V_ACT: begin
                    if (s.line >= vact) begin
                        next_s.vph = PVFT_V_BOT;
                        next_s.line = `PVFT_LINE_ONE;
                    end else begin
                        next_s.line = pvft_sat_cnt(s.line);
                    end
                end
                default: begin
                    // blank lines run on until every frame floor is met
                    if (start) begin
                        next_s.vph = PVFT_V_TOP;
                        next_s.line = `PVFT_LINE_ONE;
                    end else begin
                        next_s.line = pvft_sat_cnt(s.line);
                    end
                end
            endcase
        end
        // pins change only as the pixel clock falls, stable at its rise
        next_s.pins.line_sync = sync_next;
        next_s.pins.frame_sync = (next_s.vph == PVFT_V_TOP) && (next_s.line <= vsw);
        next_s.pins.pixel_valid = (next_s.vph == PVFT_V_ACT) && act_next;
        take = tick && next_s.pins.pixel_valid;
        if (take) begin
            next_s.pins.pixel_bus = i_pixel;
        end
        next_s.vs_age = (next_s.pins.frame_sync != s.pins.frame_sync)
            ? '0 : pvft_sat_age(s.vs_age);
        // eye may move only in a quiet gap of frame sync low
        if (tick && (i_eye_req != s.pins.stereo_eye_select) && !s.pins.frame_sync
            && !next_s.pins.frame_sync && (s.vs_age >= EYE_LIM)) begin
            next_s.pins.stereo_eye_select = i_eye_req;
            next_s.eye_age = '0;
        end else begin
            next_s.eye_age = pvft_sat_age(s.eye_age);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            s <= M_RST;
        end else begin
            s <= next_s;
        end
    end

    assign o_pixel_clk = s.pclk;
    assign o_pins = s.pins;
    assign o_pixel_take = take;
    assign o_frame_start = start;
    assign o_system_reset_low = rst_low;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    logic prev_vs;
    logic prev_hs;
    logic prev_de;
    logic rose_vs;
    logic rose_hs;
    logic rose_de;
    logic fell_de;
    pvft_cnt_t hs_len;
    pvft_cnt_t since_hs;
    pvft_cnt_t de_gap;
    pvft_cnt_t lcnt;
    pvft_cnt_t fcnt;
    pvft_cnt_t acnt;
    logic [`PVFT_CW:0] h_blank;
    logic h_tvb;

    assign rose_vs = o_pins.frame_sync && !prev_vs;
    assign rose_hs = o_pins.line_sync && !prev_hs;
    assign rose_de = o_pins.pixel_valid && !prev_de;
    assign fell_de = !o_pins.pixel_valid && prev_de;
    assign h_blank = {1'b0, lcnt} + `PVFT_LINE_ONE - {1'b0, acnt};
    // floor rebuilt from the counted lines, not from the configured count
    assign h_tvb = (h_blank > {1'b0, `PVFT_TVB_BASE})
        && (PW'(h_blank - {1'b0, `PVFT_TVB_BASE}) * PW'(arr)
        >= PW'(pvft_max(acnt, arr)) * PW'(`PVFT_TVB_MUL));

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            prev_vs <= 1'b0;
            prev_hs <= 1'b0;
            prev_de <= 1'b0;
            hs_len <= '0;
            since_hs <= '0;
            de_gap <= '0;
            lcnt <= '0;
            fcnt <= '0;
            acnt <= '0;
        end else begin
            prev_vs <= o_pins.frame_sync;
            prev_hs <= o_pins.line_sync;
            prev_de <= o_pins.pixel_valid;
            if (tick) begin
                hs_len <= o_pins.line_sync ? pvft_sat_cnt(hs_len) : '0;
                since_hs <= (o_pins.line_sync && hs_len == '0)
                    ? `PVFT_LINE_ONE : pvft_sat_cnt(since_hs);
                de_gap <= o_pins.pixel_valid ? '0 : pvft_sat_cnt(de_gap);
            end
            lcnt <= rose_vs ? '0 : (rose_hs ? pvft_sat_cnt(lcnt) : lcnt);
            fcnt <= fell_de ? '0 : (rose_hs ? pvft_sat_cnt(fcnt) : fcnt);
            acnt <= rose_vs ? '0 : (rose_de ? pvft_sat_cnt(acnt) : acnt);
        end
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);

    a_vsync_line_edge: assert property ($fell(o_pins.frame_sync) |-> $rose(o_pins.line_sync))
        else $error("frame sync fell off a line boundary");
    a_vbp_lines: assert property ($rose(o_pins.pixel_valid) |-> lcnt >= `PVFT_VBP_MIN)
        else $error("vertical back porch too short");
    a_vfp_lines: assert property ($rose(o_pins.frame_sync) |-> fcnt >= `PVFT_VFP_MIN)
        else $error("vertical front porch too short");
    a_blank_floor: assert property ($rose(o_pins.frame_sync) && acnt != '0 |-> h_tvb)
        else $error("total vertical blanking below floor");
    a_hsync_width: assert property ($fell(o_pins.line_sync)
        |-> hs_len >= `PVFT_HSW_MIN && hs_len <= `PVFT_HSW_MAX)
        else $error("line sync width out of range");
    a_hbp_clocks: assert property ($rose(o_pins.pixel_valid) |-> since_hs >= `PVFT_HBP_MIN)
        else $error("horizontal back porch too short");
    a_hfp_clocks: assert property ($rose(o_pins.line_sync) |-> de_gap >= `PVFT_HFP_MIN)
        else $error("horizontal front porch too short");
    a_eye_setup: assert property (!$stable(o_pins.frame_sync) |-> $past(s.eye_age) >= EYE_LIM)
        else $error("eye select changed too close before frame sync");
    a_eye_hold: assert property (!$stable(o_pins.stereo_eye_select)
        |-> $past(s.vs_age) >= EYE_LIM && !o_pins.frame_sync)
        else $error("eye select changed too soon after frame sync");
    a_pclk_toggle: assert property (!$past(i_sys_rst)
        |-> o_pixel_clk != $past(o_pixel_clk))
        else $error("pixel clock missed a toggle");
    a_pin_launch: assert property (!$stable(o_pins) |-> !o_pixel_clk)
        else $error("pins changed away from the pixel clock fall");

    c_frame_start: cover property ($rose(o_pins.frame_sync));
    c_active_line: cover property ($rose(o_pins.pixel_valid));
    c_eye_change: cover property (!$stable(o_pins.stereo_eye_select));
    c_eye_stall: cover property (ls && s.vph == PVFT_V_BOT && tvb_ok && !eye_ok && i_video_en);

endmodule : pvft_source

// ===== pvft_rx_model.sv
// receiving display controller model: samples the link and checks source timing
`timescale 1ns/100ps
`include "pvft_map.svh"

module pvft_rx_model #(
    parameter real EYE_NS = 1600.0
) (
    // link
    input wire logic i_pixel_clk,
    input wire pvft_pkg::pvft_pins_t i_pins,
    input wire logic i_system_reset_low,
    // geometry
    input wire logic [11:0] i_array_lines,
    // results
    output int o_viol,
    output int o_lines,
    output logic o_rx_tgl,
    output logic [`PVFT_PIX_W-1:0] o_rx_pixel
);
    import pvft_pkg::*;

    pvft_pins_t prev;
    int viol = 0;
    int lines = 0;
    int hw, hc, fc, ln, act, fa, la, blank, arr;
    bit hrise, pv_seen, fvalid, tgl;
    logic [`PVFT_PIX_W-1:0] rx_pixel = '0;
    realtime t_clk, t_eye, t_fs, t_rst;

    assign o_viol = viol;
    assign o_lines = lines;
    assign o_rx_tgl = tgl;
    assign o_rx_pixel = rx_pixel;

    // ----------------------------------------
    // reset pulse width
    // ----------------------------------------
    always @(i_system_reset_low) begin
        if (i_system_reset_low === 1'b0) t_rst = $realtime;
        else if ($realtime - t_rst < 1250.0) viol++;
    end

    // ----------------------------------------
    // link sampling; state is dropped while held in reset
    // ----------------------------------------
    always @(posedge i_pixel_clk) begin
        arr = int'(i_array_lines);
        if (i_system_reset_low !== 1'b1) begin
            prev = i_pins;
            hrise = 0;
            pv_seen = 0;
            fvalid = 0;
            ln = 0;
            act = 0;
            t_clk = 0.0;
            t_eye = -1.0e9;
            t_fs = -1.0e9;
        end else begin
            if (t_clk > 0.0 && ($realtime - t_clk < 6.45 || $realtime - t_clk > 1000.0)) viol++;
            t_clk = $realtime;
            hc++;
            fc++;
            if (i_pins.line_sync && !prev.line_sync) begin
                if (pv_seen && fc < 8) viol++;
                hw = 0;
                hc = 0;
                hrise = 1;
                pv_seen = 0;
                ln++;
            end
            if (i_pins.line_sync) hw++;
            if (hrise && prev.line_sync && !i_pins.line_sync && (hw < 4 || hw > 128)) viol++;
            if (i_pins.pixel_valid && !prev.pixel_valid) begin
                if (hrise && hc < 4) viol++;
                if (act == 0) fa = ln - 1;
                la = ln - 1;
                act++;
            end
            if (prev.pixel_valid && !i_pins.pixel_valid) begin
                fc = 0;
                pv_seen = 1;
            end
            if (fvalid && prev.frame_sync && !i_pins.frame_sync && ln < 2) viol++;
            if (i_pins.frame_sync && !prev.frame_sync) begin
                if (fvalid && act > 0) begin
                    if (fa < 2) viol++;
                    if (ln - 1 - (la + 1) < 1) viol++;
                    blank = ln - 1 - act;
                    if (blank <= 6 || (blank - 6) * arr < 8 * (act > arr ? act : arr)) viol++;
                    lines = act;
                end
                fvalid = 1;
                ln = 1;
                act = 0;
            end
            if (i_pins.frame_sync != prev.frame_sync) begin
                if ($realtime - t_eye < EYE_NS - 0.5) viol++;
                t_fs = $realtime;
            end
            if (i_pins.stereo_eye_select != prev.stereo_eye_select) begin
                if ($realtime - t_fs < EYE_NS - 0.5) viol++;
                t_eye = $realtime;
            end
            if (i_pins.pixel_valid) begin
                rx_pixel = i_pins.pixel_bus;
                tgl = !tgl;
            end
            prev = i_pins;
        end
    end
endmodule : pvft_rx_model

// ===== parallel_video_frame_timing_tb_top.sv
// self-checking bench for the parallel video frame source
`timescale 1ns/100ps
`include "pvft_map.svh"

module parallel_video_frame_timing_tb_top;
    import pvft_pkg::*;

    logic i_core_clk, i_sys_rst, i_video_en, i_reset_req, i_eye_req;
    pvft_hcfg_t i_hcfg;
    pvft_vcfg_t i_vcfg;
    logic [`PVFT_PIX_W-1:0] i_pixel, rx_pixel;
    logic o_pixel_take, o_frame_start, o_pixel_clk, o_system_reset_low, rx_tgl, last_tgl;
    pvft_pins_t o_pins;
    logic [11:0] arr;
    int viol, lines, num_errors, comparisons, n, seed;
    logic [`PVFT_PIX_W-1:0] pix_q[$];

    pvft_source #(.EYE_HOLD_CYC(200)) dut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
        .i_video_en(i_video_en), .i_reset_req(i_reset_req), .i_eye_req(i_eye_req),
        .i_hcfg(i_hcfg), .i_vcfg(i_vcfg), .i_pixel(i_pixel), .o_pixel_take(o_pixel_take),
        .o_frame_start(o_frame_start), .o_pixel_clk(o_pixel_clk), .o_pins(o_pins),
        .o_system_reset_low(o_system_reset_low));

    pvft_rx_model #(.EYE_NS(1600.0)) model (.i_pixel_clk(o_pixel_clk), .i_pins(o_pins),
        .i_system_reset_low(o_system_reset_low), .i_array_lines(arr), .o_viol(viol),
        .o_lines(lines), .o_rx_tgl(rx_tgl), .o_rx_pixel(rx_pixel));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic test_done();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    task automatic do_reset();
        @(negedge i_core_clk);
        i_sys_rst = 1'b1;
        repeat (20) @(negedge i_core_clk);
        check("pins in reset", {o_pins.frame_sync, o_pins.line_sync, o_system_reset_low}, 0);
        i_sys_rst = 1'b0;
        pix_q.delete();
    endtask : do_reset

    // bounded wait; a frame with extra eye blanking still fits
    task automatic wait_frame();
        n = 0;
        while (o_frame_start !== 1'b1 && n < 40000) begin
            @(negedge i_core_clk);
            n++;
        end
        if (n >= 40000) check("frame start timeout", 0, 1);
        @(negedge i_core_clk);
    endtask : wait_frame

    // ----------------------------------------
    // reference pixel stream, compared at every received pixel
    // ----------------------------------------
    always @(posedge i_core_clk) begin
        if (o_pixel_take === 1'b1) pix_q.push_back(i_pixel);
    end

    always @(negedge i_core_clk) begin
        if (rx_tgl !== last_tgl) begin
            last_tgl = rx_tgl;
            if (pix_q.size() == 0) check("pixel queue empty", 0, 1);
            else check("pixel", rx_pixel, pix_q.pop_front());
        end
    end

    initial begin
        i_core_clk = 1'b0;
        forever #4 i_core_clk = ~i_core_clk;
    end

    initial begin
        #800000;
        num_errors++;
        test_done();
    end

    // ----------------------------------------
    // main sequence: boundary, clamped and random geometries
    // ----------------------------------------
    initial begin
        {i_sys_rst, i_video_en, i_reset_req, i_eye_req, last_tgl} = 5'h10;
        {i_hcfg, i_vcfg, i_pixel, arr} = '0;
        seed = $urandom(97027);
        fork
            forever begin
                @(negedge i_core_clk);
                i_pixel = `PVFT_PIX_W'($urandom);
            end
        join_none
        for (int c = 0; c < 4; c++) begin
            // geometry moves only while held in reset
            if (c != 0) i_sys_rst = 1'b1;
            case (c)
                0: begin
                    i_hcfg = '{12'h004, 12'h004, 12'h008, 12'h008};
                    i_vcfg = '{12'h001, 12'h002, 12'h003, 12'h001, 12'h001};
                end
                1: begin
                    i_hcfg = '{12'h0C0, 12'h004, 12'h004, 12'h008};
                    i_vcfg = '{12'h001, 12'h002, 12'h002, 12'h001, 12'h004};
                end
                2: begin
                    // out of range figures are clamped, never sent as is
                    i_hcfg = '{12'h002, 12'h001, 12'h003, 12'h002};
                    i_vcfg = '{12'h000, 12'h000, 12'h002, 12'h000, 12'h000};
                end
                default: begin
                    i_hcfg = '{12'(4 + $urandom_range(15)), 12'(4 + $urandom_range(5)),
                        12'(1 + $urandom_range(15)), 12'(8 + $urandom_range(7))};
                    i_vcfg = '{12'(1 + $urandom_range(2)), 12'(2 + $urandom_range(2)),
                        12'(1 + $urandom_range(5)), 12'(1 + $urandom_range(2)),
                        12'(1 + $urandom_range(5))};
                end
            endcase
            arr = (i_vcfg.array_used_lines == 12'h000) ? 12'h001 : i_vcfg.array_used_lines;
            i_video_en = 1'b1;
            do_reset();
            if (c == 0) begin
                repeat (50) @(negedge i_core_clk);
                i_reset_req = 1'b1;
                @(negedge i_core_clk);
                i_reset_req = 1'b0;
                n = 0;
                while (o_system_reset_low !== 1'b1 && n < 400) begin
                    @(posedge i_core_clk);
                    #1;
                    n++;
                end
                check("reset low edges", n, 157);
            end
            wait_frame();
            i_eye_req = ~i_eye_req;
            wait_frame();
            wait_frame();
            repeat (8) @(negedge i_core_clk);
            check("active lines", lines, 32'(i_vcfg.source_active_lines));
            n = 0;
            while (o_pins.stereo_eye_select !== i_eye_req && n < 20000) begin
                @(negedge i_core_clk);
                n++;
            end
            check("eye select", o_pins.stereo_eye_select, i_eye_req);
            check("link timing faults", viol, 0);
        end
        // with video disabled the frame already started runs out and no new frame starts
        i_video_en = 1'b0;
        n = 0;
        repeat (6000) begin
            @(negedge i_core_clk);
            if (o_frame_start === 1'b1) n++;
        end
        check("frames while disabled", n, 0);
        check("final timing faults", viol, 0);
        test_done();
    end
endmodule : parallel_video_frame_timing_tb_top
